// *** hw/adcsq_top.sv ***
// adcsq_top: converter sequencer with sample/hold, temperature, trips
//
// Summary of operation
// - mux selects 16 single or 8 pairs
// - continuous polling or single burst then shutdown
// - four ranges, each with trim register
// - conversion clock divided, minimum ratio eight
// - 15 conversion clocks plus processing
// - two conversions averaged per result
// - per-channel differential, align, acquisition, range
// - twenty-four 16-bit result buffers
// - ready flag after programmed sample count
// - ready flag cleared by software or restart
// - two sample/hold enables, independent
// - strobe captures, converts, stores sample/hold
// - shared strobe or separate strobes
// - sample/hold ready flag, software clears
// - remote diode biased at several currents
// - three temperature channels enabled independently
// - temperature ready flags, software clears
// - temperature lsb is 0.0625 C
// - time-slice voltage, sample/hold, temperature
// - 8-bit trips round robin, high/low
// - 32 thresholds, comparator clocking supplied
// - trips run in idle cycles except the first one after a job, including one that launches a conversion
`timescale 1ns/1ps
module adcsq_top (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 sys_rst,
  // control
  input  wire logic                 conv_enable,
  input  wire logic                 continuous_mode,
  input  wire logic [7:0]           clk_div,
  input  wire logic [15:0]          chan_select,
  input  wire adcsq_pkg::adcsq_chcfg_t chan_cfg [16],
  input  wire logic [15:0]          range_trim_one,
  input  wire logic [15:0]          range_trim_two,
  input  wire logic [15:0]          range_trim_three,
  input  wire logic [15:0]          range_trim_four,
  input  wire logic [7:0]           sample_count,
  input  wire logic                 clear_result_ready,
  // sample/hold control
  input  wire logic [1:0]           sample_hold_control,
  input  wire logic                 shared_strobe_select,
  input  wire logic                 sample_strobe_pin,
  input  wire logic [1:0]           clear_sh_ready,
  // temperature control
  input  wire logic [2:0]           temperature_channel_control,
  input  wire logic [2:0]           clear_temp_ready,
  // quick trips
  input  wire logic [15:0]          trip_list,
  input  wire logic [7:0]           trip_low [16],
  input  wire logic [7:0]           trip_high [16],
  input  wire logic [15:0]          clear_trip,
  input  wire logic                 cmp_above,
  input  wire logic                 cmp_below,
  // analog converter
  input  wire logic                 conv_done,
  input  wire logic [12:0]          conv_data,
  output adcsq_pkg::adcsq_conv_t    conv_req,
  output logic                      conversion_clock,
  output logic                      conv_powerdown,
  // comparator
  output logic                      cmp_clk,
  output logic [3:0]                cmp_mux,
  output logic [7:0]                cmp_low,
  output logic [7:0]                cmp_high,
  // results and flags
  input  wire logic [4:0]           buf_rd_addr,
  output logic      [15:0]          buf_rd_data,
  output logic                      converter_result_ready_flag,
  output logic [1:0]                sample_hold_ready_flag,
  output logic                      die_temp_ready_flag,
  output logic                      remote0_temp_ready_flag,
  output logic                      remote1_temp_ready_flag,
  output logic [15:0]               trip_flag
);
  import adcsq_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // functions

  // trim register for a range code
  function automatic logic [15:0] trim_of(input logic [1:0] r);
    unique case (r)
      2'h0: trim_of = range_trim_one;
      2'h1: trim_of = range_trim_two;
      2'h2: trim_of = range_trim_three;
      2'h3: trim_of = range_trim_four;
    endcase
  endfunction

  // next set bit after position p, wrapping
  function automatic logic [3:0] next_of(input logic [15:0] m,
                                         input logic [3:0] p);
    logic [3:0] r;
    logic [3:0] k;
    r = p;
    for (int i = 16; i >= 1; i--) begin
      k = 4'(p + 4'(i));
      if (m[k]) r = k;
    end
    next_of = r;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // strobe synchroniser: three stages, change when stage 2 and 3 agree

  logic [2:0] strb_sync_q;  // sync chain
  logic       strb_lvl_q;   // filtered level
  logic       strb_rise;    // filtered rising edge

  // sync chain
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      strb_sync_q <= 3'h0;
    end else begin
      strb_sync_q <= {strb_sync_q[1:0], sample_strobe_pin};
    end
  end

  // agreement filter
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      strb_lvl_q <= 1'b0;
    end else if (strb_sync_q[1] == strb_sync_q[2]) begin
      strb_lvl_q <= strb_sync_q[2];
    end
  end

  assign strb_rise = (strb_sync_q[1] == strb_sync_q[2]) &&
                     strb_sync_q[2] && !strb_lvl_q;

  ////////////////////////////////////////////////////////////////////
  // conversion clock divider

  logic [7:0] div_cnt_q;   // divider count
  logic [7:0] div_eff;     // clamped ratio
  logic       cclk_tick;   // one core cycle per conversion clock

  assign div_eff   = (clk_div < DIV_MIN) ? DIV_MIN : clk_div;
  assign cclk_tick = (div_cnt_q == 8'h00);

  // divider and clock output
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_cnt_q        <= 8'h00;
      conversion_clock <= 1'b0;
    end else begin
      div_cnt_q        <= cclk_tick ? 8'(div_eff - 8'h01)
                                    : 8'(div_cnt_q - 8'h01);
      conversion_clock <= (div_cnt_q >= {1'b0, div_eff[7:1]});
    end
  end

  ////////////////////////////////////////////////////////////////////
  // job slicer state

  typedef enum {S_IDLE, S_CONV, S_PROC, S_STORE} st_t;
  st_t         st_q;          // sequencer state
  adcsq_job_t  job_q;         // current job kind
  logic [3:0]  vch_q;         // voltage channel pointer
  logic [1:0]  sub_q;         // sh or temp index
  logic        half_q;        // first or second conversion
  logic [1:0]  bias_q;        // diode bias step
  logic [7:0]  pcnt_q;        // processing count
  logic [13:0] acc_q;         // sum of two conversions
  logic [1:0]  sh_pend_q;     // sample/hold pending
  logic [2:0]  tmp_pend_q;    // temperature pending
  logic [7:0]  smp_cnt_q;     // completed samples
  logic        burst_done_q;  // single burst finished
  logic        run_q;         // conversion process running
  logic        qt_slot_q;     // comparator owns the pins
  logic        wr_en_q;
  logic [4:0]  wr_addr_q;
  logic [15:0] wr_data_q;
  logic [15:0] res;           // aligned result
  logic        vwant;         // voltage work available

  assign vwant = conv_enable && (chan_select != 16'h0000) &&
                 (continuous_mode || !burst_done_q);

  always_comb begin
    res = 16'h0000;
    if (job_q == JOB_TEMP) begin
      res = {1'b0, acc_q[13:1], 2'b00} >> (3 - TEMP_FRAC + 1);
    end else if (job_q == JOB_VOLT && chan_cfg[vch_q].align_left) begin
      res = {acc_q[13:1], 3'b000};
    end else begin
      res = {3'b000, acc_q[13:1]};
    end
  end

  // start of a conversion process
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_q <= 1'b0;
    end else begin
      run_q <= vwant;
    end
  end

  // pending sample/hold and temperature work
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sh_pend_q  <= 2'h0;
      tmp_pend_q <= 3'h0;
    end else begin
      if (strb_rise) begin
        if (shared_strobe_select) begin
          sh_pend_q <= sh_pend_q | sample_hold_control;
        end else if (sample_hold_control[0] && !sh_pend_q[0]) begin
          // separate strobes: one pair per strobe, pair a first
          sh_pend_q[0] <= 1'b1;
        end else begin
          sh_pend_q[1] <= sh_pend_q[1] | sample_hold_control[1];
        end
      end
      tmp_pend_q <= tmp_pend_q | temperature_channel_control;
      if (st_q == S_STORE && !half_q) begin
        if (job_q == JOB_SH) sh_pend_q[sub_q[0]] <= 1'b0;
        if (job_q == JOB_TEMP && bias_q == 2'h3) begin
          tmp_pend_q[sub_q] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q      <= S_IDLE;
      job_q     <= JOB_VOLT;
      vch_q     <= 4'h0;
      sub_q     <= 2'h0;
      half_q    <= 1'b0;
      bias_q    <= 2'h0;
      pcnt_q    <= 8'h00;
      acc_q     <= 14'h0000;
      qt_slot_q <= 1'b1;
      conv_req  <= '0;
      wr_en_q   <= 1'b0;
      wr_addr_q <= 5'h00;
      wr_data_q <= 16'h0000;
    end else begin
      wr_en_q        <= 1'b0;
      conv_req.start <= 1'b0;
      unique case (st_q)
        S_IDLE: begin
          qt_slot_q <= 1'b1;
          // sample/hold first, then temperature, then voltage
          if (cclk_tick && (sh_pend_q != 2'h0 ||
              (tmp_pend_q & temperature_channel_control) != 3'h0 ||
              vwant)) begin
            qt_slot_q <= 1'b0;
            half_q    <= 1'b0;
            acc_q     <= 14'h0000;
            st_q      <= S_CONV;
            conv_req.start <= 1'b1;
            if (sh_pend_q != 2'h0) begin
              job_q <= JOB_SH;
              sub_q <= sh_pend_q[0] ? 2'h0 : 2'h1;
              conv_req.mux  <= sh_pend_q[0] ? 4'h2 : 4'hc;
              conv_req.diff <= 1'b1;
              conv_req.range <= 2'h0;
              conv_req.trim  <= trim_of(2'h0);
            end else if ((tmp_pend_q & temperature_channel_control)
                         != 3'h0) begin
              job_q <= JOB_TEMP;
              // die sensor or remote diode pins with bias steps
              sub_q <= tmp_pend_q[0] ? 2'h0 :
                       (tmp_pend_q[1] ? 2'h1 : 2'h2);
              conv_req.mux  <= tmp_pend_q[0] ? 4'h0 :
                               (tmp_pend_q[1] ? 4'h8 : 4'ha);
              conv_req.diff <= 1'b1;
              conv_req.bias <= bias_q;
            end else begin
              job_q <= JOB_VOLT;
              conv_req.mux     <= chan_cfg[vch_q].diff ?
                                  {vch_q[2:0], 1'b0} : vch_q;
              conv_req.diff    <= chan_cfg[vch_q].diff;
              conv_req.ext_acq <= chan_cfg[vch_q].ext_acq;
              conv_req.range   <= chan_cfg[vch_q].range;
              conv_req.trim    <= trim_of(chan_cfg[vch_q].range);
            end
          end
        end
        S_CONV: begin
          if (conv_done) begin
            acc_q  <= 14'(acc_q + {1'b0, conv_data});
            pcnt_q <= 8'(PROC_CYC);
            st_q   <= S_PROC;
          end
        end
        S_PROC: begin
          pcnt_q <= 8'(pcnt_q - 8'h01);
          if (pcnt_q == 8'h01) begin
            if (!half_q) begin
              half_q <= 1'b1;
              conv_req.start <= 1'b1;
              st_q   <= S_CONV;
            end else begin
              half_q <= 1'b0;
              st_q   <= S_STORE;
            end
          end
        end
        S_STORE: begin
          wr_en_q   <= 1'b1;
          wr_data_q <= res;
          unique case (job_q)
            JOB_SH:   wr_addr_q <= sub_q[0] ? BUF_SH1 : BUF_SH0;
            JOB_TEMP: wr_addr_q <= 5'(BUF_DIE + 5'(sub_q));
            default:  wr_addr_q <= {1'b0, vch_q};
          endcase
          if (job_q == JOB_TEMP) begin
            bias_q <= 2'(bias_q + 2'h1);
          end
          if (job_q == JOB_VOLT) begin
            vch_q <= next_of(chan_select, vch_q);
          end
          st_q <= S_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // counting, burst and flags

  logic wrap;  // pointer wrap ends a single burst
  assign wrap = (st_q == S_STORE) && (job_q == JOB_VOLT) &&
                (next_of(chan_select, vch_q) <= vch_q);

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      burst_done_q   <= 1'b0;
      conv_powerdown <= 1'b1;
    end else begin
      if (!conv_enable) burst_done_q <= 1'b0;
      else if (wrap && !continuous_mode) burst_done_q <= 1'b1;
      conv_powerdown <= (st_q == S_IDLE) && !vwant &&
                        sh_pend_q == 2'h0 && tmp_pend_q == 3'h0;
    end
  end

  // sample count and voltage ready flag
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      smp_cnt_q                   <= 8'h00;
      converter_result_ready_flag <= 1'b0;
    end else begin
      if (vwant && !run_q) smp_cnt_q <= 8'h00;
      else if (st_q == S_STORE && job_q == JOB_VOLT) begin
        smp_cnt_q <= 8'(smp_cnt_q + 8'h01);
      end
      if (st_q == S_STORE && job_q == JOB_VOLT &&
          8'(smp_cnt_q + 8'h01) == sample_count) begin
        converter_result_ready_flag <= 1'b1;
      end else if (clear_result_ready || (vwant && !run_q)) begin
        converter_result_ready_flag <= 1'b0;
      end
    end
  end

  // sticky flags, set wins over clear
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sample_hold_ready_flag  <= 2'h0;
      die_temp_ready_flag     <= 1'b0;
      remote0_temp_ready_flag <= 1'b0;
      remote1_temp_ready_flag <= 1'b0;
    end else begin
      logic [1:0] shs;
      logic [2:0] tps;
      shs = '0;
      tps = '0;
      if (st_q == S_STORE && job_q == JOB_SH) shs[sub_q[0]] = 1'b1;
      if (st_q == S_STORE && job_q == JOB_TEMP && bias_q == 2'h3) begin
        tps[sub_q] = 1'b1;
      end
      sample_hold_ready_flag  <= shs | (sample_hold_ready_flag &
                                        ~clear_sh_ready);
      die_temp_ready_flag     <= tps[0] | (die_temp_ready_flag &
                                           !clear_temp_ready[0]);
      remote0_temp_ready_flag <= tps[1] | (remote0_temp_ready_flag &
                                           !clear_temp_ready[1]);
      remote1_temp_ready_flag <= tps[2] | (remote1_temp_ready_flag &
                                           !clear_temp_ready[2]);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // quick trips

  logic [3:0] qt_ch_q;   // trip channel pointer
  logic [1:0] qt_ph_q;   // comparator phase

  // round robin only in comparator slots
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      qt_ch_q   <= 4'h0;
      qt_ph_q   <= 2'h0;
      cmp_clk   <= 1'b0;
      cmp_mux   <= 4'h0;
      cmp_low   <= 8'h00;
      cmp_high  <= 8'h00;
      trip_flag <= 16'h0000;
    end else begin
      cmp_clk <= 1'b0;
      if (qt_slot_q && st_q == S_IDLE && trip_list != 16'h0000) begin
        qt_ph_q <= 2'(qt_ph_q + 2'h1);
        unique case (qt_ph_q)
          2'h0: begin
            cmp_mux  <= qt_ch_q;
            cmp_low  <= trip_low[qt_ch_q];
            cmp_high <= trip_high[qt_ch_q];
          end
          2'h1: cmp_clk <= 1'b1;
          2'h2: cmp_clk <= 1'b0;
          2'h3: qt_ch_q <= next_of(trip_list, qt_ch_q);
        endcase
      end
      trip_flag <= (trip_flag & ~clear_trip) |
                   ((qt_ph_q == 2'h3 && qt_slot_q && st_q == S_IDLE &&
                     (cmp_above || cmp_below)) ?
                    (16'h0001 << cmp_mux) : 16'h0000);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // result memory

  adcsq_buf_mem u_mem (
    .sys_clk (sys_clk),
    .wr_en   (wr_en_q),
    .wr_addr (wr_addr_q),
    .wr_data (wr_data_q),
    .rd_addr (buf_rd_addr),
    .rd_data (buf_rd_data)
  );
endmodule

// *** hw/adcsq_pkg.sv ***
// adcsq_pkg: constants and types for the converter sequencer
package adcsq_pkg;
  // buffer count
  localparam int NUM_BUF     = 24;
  // result processing in core cycles
  localparam int PROC_CYC    = 4;
  // fastest divide ratio
  localparam logic [7:0] DIV_MIN = 8'h08;
  // reserved buffer locations
  localparam logic [4:0] BUF_SH0   = 5'h10;
  localparam logic [4:0] BUF_SH1   = 5'h11;
  localparam logic [4:0] BUF_DIE   = 5'h12;
  localparam logic [4:0] BUF_REM0  = 5'h13;
  localparam logic [4:0] BUF_REM1  = 5'h14;
  // 0.0625 C per lsb: four fraction bits
  localparam int TEMP_FRAC   = 4;

  // per-channel settings
  typedef struct packed {
    logic       diff;      // differential pair select
    logic       align_left; // result alignment
    logic       ext_acq;   // extended acquisition
    logic [1:0] range;     // full-scale range select
  } adcsq_chcfg_t;

  // analog converter request
  typedef struct packed {
    logic       start;
    logic [3:0] mux;
    logic       diff;
    logic       ext_acq;
    logic [1:0] range;
    logic [15:0] trim;
    logic [1:0] bias;      // diode bias current step
  } adcsq_conv_t;

  // job kinds handled by the slicer
  typedef enum logic [1:0] {
    JOB_VOLT, JOB_SH, JOB_TEMP
  } adcsq_job_t;
endpackage

// *** hw/adcsq_buf_mem.sv ***
// adcsq_buf_mem: 24 x 16 result buffer memory with registered read
`timescale 1ns/1ps
module adcsq_buf_mem (
  // clock
  input  wire logic        sys_clk,
  // write port
  input  wire logic        wr_en,
  input  wire logic [4:0]  wr_addr,
  input  wire logic [15:0] wr_data,
  // read port
  input  wire logic [4:0]  rd_addr,
  output logic      [15:0] rd_data
);
  import adcsq_pkg::*;

  logic [15:0] mem [NUM_BUF];  // result storage

  // write side
  always_ff @(posedge sys_clk) begin
    if (wr_en && (wr_addr < 5'(NUM_BUF))) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read
  always_ff @(posedge sys_clk) begin
    if (rd_addr < 5'(NUM_BUF)) begin
      rd_data <= mem[rd_addr];
    end else begin
      rd_data <= 16'h0000;
    end
  end
endmodule

// *** test/adcsq_props.sv ***
// adcsq_props: port-level checker for the converter sequencer
`timescale 1ns/1ps
module adcsq_props (
  // clock and reset
  input wire logic                    sys_clk,
  input wire logic                    sys_rst,
  // converter side
  input wire adcsq_pkg::adcsq_conv_t  conv_req,
  input wire logic                    conv_done,
  input wire logic                    conversion_clock,
  input wire logic                    conv_powerdown,
  // flags and clears
  input wire logic [1:0]              sample_hold_ready_flag,
  input wire logic [1:0]              clear_sh_ready,
  input wire logic                    die_temp_ready_flag,
  input wire logic [2:0]              clear_temp_ready,
  input wire logic [15:0]             trip_flag,
  input wire logic [15:0]             clear_trip
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////
  property p_start_pulse; conv_req.start |=> !conv_req.start; endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("start longer than one cycle");
  property p_proc_gap; conv_done |=> !conv_req.start [*4]; endproperty
  a_proc_gap: assert property (p_proc_gap)
    else $error("start inside processing time");
  property p_one_out; conv_req.start |=> !conv_req.start [*8]; endproperty
  a_one_out: assert property (p_one_out)
    else $error("second start before conversion done");
  property p_div;
    $changed(conversion_clock) |=> $stable(conversion_clock) [*3];
  endproperty
  a_div: assert property (p_div)
    else $error("conversion clock faster than ratio eight");
  property p_pd; conv_req.start |-> !conv_powerdown; endproperty
  a_pd: assert property (p_pd)
    else $error("start while powered down");
  property p_sh_hold;
    sample_hold_ready_flag[0] && !clear_sh_ready[0]
      |=> sample_hold_ready_flag[0];
  endproperty
  a_sh_hold: assert property (p_sh_hold)
    else $error("sample/hold flag dropped without clear");
  property p_die_hold;
    die_temp_ready_flag && !clear_temp_ready[0] |=> die_temp_ready_flag;
  endproperty
  a_die_hold: assert property (p_die_hold)
    else $error("die flag dropped without clear");
  property p_trip_hold; trip_flag[1] && !clear_trip[1] |=> trip_flag[1];
  endproperty
  a_trip_hold: assert property (p_trip_hold)
    else $error("trip flag dropped without clear");
endmodule

// *** test/adcsq_analog_model.sv ***
// adcsq_analog_model: behavioural converter and comparator
`timescale 1ns/1ps
module adcsq_analog_model #(parameter int LAT = 120) (
  // clock
  input wire logic                    sys_clk,
  // converter side
  input wire adcsq_pkg::adcsq_conv_t  conv_req,
  output logic                        conv_done,
  output logic [12:0]                 conv_data,
  // comparator side
  input wire logic [3:0]              cmp_mux,
  input wire logic [7:0]              cmp_low,
  input wire logic [7:0]              cmp_high,
  output logic                        cmp_above,
  output logic                        cmp_below
);
  int         cnt = 0;       // cycles left in conversion
  logic       odd = 1'h0;    // second of a pair
  logic [3:0] mux_q = 4'h0;  // channel latched at start
  initial conv_done = 1'h0;
  initial conv_data = 13'h0;
  // one conversion, data only valid with done
  always @(posedge sys_clk) begin
    conv_done <= 1'h0;
    conv_data <= ~conv_data;
    if (conv_req.start) begin
      cnt <= LAT;
      mux_q <= conv_req.mux;
    end else if (cnt == 1) begin
      conv_done <= 1'h1;
      conv_data <= {mux_q, 9'h040} + {11'h0, odd, 1'h0};
      odd <= ~odd;
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
  // channel level is sixteen times its index
  assign cmp_above = {cmp_mux, 4'h0} > cmp_high;
  assign cmp_below = {cmp_mux, 4'h0} < cmp_low;
endmodule

// *** test/adcsq_top_tb_top.sv ***
// adcsq_top_tb_top: self-checking bench for the converter sequencer
`timescale 1ns/1ps
module adcsq_top_tb_top;
  import adcsq_pkg::*;
  typedef struct { logic [4:0] addr; logic [15:0] exp; } adcsq_row_t;
  logic sys_clk = 1'h0, sys_rst = 1'h1, vphase = 1'h0;
  logic conv_enable, continuous_mode, clear_result_ready, conv_done;
  logic shared_strobe_select, sample_strobe_pin, cmp_above, cmp_below;
  logic conversion_clock, conv_powerdown, cmp_clk;
  logic converter_result_ready_flag, die_temp_ready_flag;
  logic remote0_temp_ready_flag, remote1_temp_ready_flag;
  logic [1:0]  sample_hold_control, clear_sh_ready, sample_hold_ready_flag;
  logic [2:0]  temperature_channel_control, clear_temp_ready;
  logic [3:0]  cmp_mux;
  logic [4:0]  buf_rd_addr;
  logic [7:0]  clk_div, sample_count, cmp_low, cmp_high;
  logic [7:0]  trip_low [16], trip_high [16];
  logic [12:0] conv_data;
  logic [15:0] chan_select, trip_list, clear_trip, buf_rd_data, trip_flag;
  logic [15:0] range_trim_one, range_trim_two;
  logic [15:0] range_trim_three, range_trim_four, trims [4];
  adcsq_chcfg_t chan_cfg [16];
  adcsq_conv_t  conv_req;
  int failures = 0, comparisons = 0, cyc = 0;
  logic [1:0] r;  // range of the channel being started
  // channel, expected mean of the pair
  adcsq_row_t rows [3] = '{'{5'h00, 16'h0041}, '{5'h02, 16'h0441},
                           '{5'h0f, 16'h1e41}};
  ////////////////////////////////////////////////////////////////////////
  adcsq_top adcsq_top_i (.sys_clk, .sys_rst, .conv_enable, .continuous_mode,
    .clk_div, .chan_select, .chan_cfg, .range_trim_one, .range_trim_two,
    .range_trim_three, .range_trim_four, .sample_count, .clear_result_ready,
    .sample_hold_control, .shared_strobe_select, .sample_strobe_pin,
    .clear_sh_ready, .temperature_channel_control, .clear_temp_ready,
    .trip_list, .trip_low, .trip_high, .clear_trip, .cmp_above, .cmp_below,
    .conv_done, .conv_data, .conv_req, .conversion_clock, .conv_powerdown,
    .cmp_clk, .cmp_mux, .cmp_low, .cmp_high, .buf_rd_addr, .buf_rd_data,
    .converter_result_ready_flag, .sample_hold_ready_flag,
    .die_temp_ready_flag, .remote0_temp_ready_flag,
    .remote1_temp_ready_flag, .trip_flag);
  adcsq_analog_model #(.LAT(20)) adcsq_analog_model_i (.sys_clk, .conv_req,
    .conv_done, .conv_data, .cmp_mux, .cmp_low, .cmp_high, .cmp_above,
    .cmp_below);
  ////////////////////////////////////////////////////////////////////////
  // clock and run ceiling
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      results();
    end
  end
  // compare tasks and verdict
  task automatic chk_bit(string nm, logic e, logic g);
    chk_word(nm, {15'h0, e}, {15'h0, g});
  endtask
  task automatic chk_word(string nm, logic [15:0] e, logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic results();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // pulse on the sample pin
  task automatic strobe();
    sample_strobe_pin = 1'h1;
    repeat (4) @(negedge sys_clk);
    sample_strobe_pin = 1'h0;
    repeat (4) @(negedge sys_clk);
  endtask
  // per-channel settings seen on each voltage start while vphase is set
  always @(negedge sys_clk) begin
    if (vphase && conv_req.start === 1'h1) begin
      r = chan_cfg[conv_req.mux].range;
      chk_word("trim", trims[r], conv_req.trim);
      chk_word("range", {14'h0, r}, {14'h0, conv_req.range});
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {conv_enable, continuous_mode, clear_result_ready} = 3'h0;
    {shared_strobe_select, sample_strobe_pin} = 2'h0;
    {sample_hold_control, clear_sh_ready, buf_rd_addr} = 9'h0;
    {temperature_channel_control, clear_temp_ready, clear_trip} = 22'h0;
    trims = '{16'h1111, 16'h2222, 16'h3333, 16'h4444};
    {range_trim_one, range_trim_two} = {trims[0], trims[1]};
    {range_trim_three, range_trim_four} = {trims[2], trims[3]};
    clk_div = 8'h04;
    sample_count = 8'h03;
    chan_select = 16'h8005;
    trip_list = 16'h0000;
    chan_cfg = '{default: '0};
    trip_low = '{default: 8'h00};
    trip_high = '{default: 8'hff};
    chan_cfg[2].range = 2'h2;
    chan_cfg[15].range = 2'h3;
    repeat (3) @(negedge sys_clk);
    sys_rst = 1'h0;
    chk_bit("powerdown", 1'h1, conv_powerdown);
    chk_bit("result flag", 1'h0, converter_result_ready_flag);
    conv_enable = 1'h1;
    vphase = 1'h1;
    wait (converter_result_ready_flag === 1'h1) @(negedge sys_clk);
    chk_bit("result flag", 1'h1, converter_result_ready_flag);
    wait (conv_powerdown === 1'h1) @(negedge sys_clk);
    chk_bit("burst end", 1'h1, conv_powerdown);
    vphase = 1'h0;
    foreach (rows[k]) begin
      buf_rd_addr = rows[k].addr;
      repeat (2) @(negedge sys_clk);
      chk_word("buffer", rows[k].exp, buf_rd_data);
    end
    // a new process clears the flag by itself
    conv_enable = 1'h0;
    @(negedge sys_clk);
    conv_enable = 1'h1;
    repeat (2) @(negedge sys_clk);
    chk_bit("restart clear", 1'h0, converter_result_ready_flag);
    wait (conv_powerdown === 1'h1) @(negedge sys_clk);
    conv_enable = 1'h0;
    clear_result_ready = 1'h1;
    @(negedge sys_clk);
    clear_result_ready = 1'h0;
    @(negedge sys_clk);
    chk_bit("sw clear", 1'h0, converter_result_ready_flag);
    // pair a alone, then both on one shared strobe
    sample_hold_control = 2'h1;
    strobe();
    wait (sample_hold_ready_flag[0] === 1'h1) @(negedge sys_clk);
    chk_word("sh flags", 16'h0001, {14'h0, sample_hold_ready_flag});
    clear_sh_ready = 2'h1;
    @(negedge sys_clk);
    clear_sh_ready = 2'h0;
    @(negedge sys_clk);
    chk_bit("sh clear", 1'h0, sample_hold_ready_flag[0]);
    {sample_hold_control, shared_strobe_select} = 3'h7;
    strobe();
    wait (sample_hold_ready_flag === 2'h3) @(negedge sys_clk);
    chk_word("sh shared", 16'h0003, {14'h0, sample_hold_ready_flag});
    // die channel only
    temperature_channel_control = 3'h1;
    wait (die_temp_ready_flag === 1'h1) @(negedge sys_clk);
    chk_bit("die flag", 1'h1, die_temp_ready_flag);
    chk_bit("remote flag", 1'h0, remote0_temp_ready_flag);
    // channel 1 below its low threshold, channel 0 inside
    trip_low[1] = 8'h20;
    trip_list = 16'h0003;
    wait (trip_flag[1] === 1'h1) @(negedge sys_clk);
    chk_word("trip flags", 16'h0002, trip_flag);
    trip_low[1] = 8'h00;
    repeat (100) @(negedge sys_clk);
    clear_trip = 16'h0002;
    @(negedge sys_clk);
    clear_trip = 16'h0000;
    @(negedge sys_clk);
    chk_word("trip clear", 16'h0000, trip_flag);
    results();
  end
endmodule
bind adcsq_top adcsq_props adcsq_props_i (.sys_clk, .sys_rst, .conv_req,
  .conv_done, .conversion_clock, .conv_powerdown, .sample_hold_ready_flag,
  .clear_sh_ready, .die_temp_ready_flag, .clear_temp_ready, .trip_flag,
  .clear_trip);
